// ---- tmr16_defines.vh ----
// Purpose: Shared constants of the 16-bit interval match timer
// Assumes: 8-bit register port, one clock domain
// Notes:   Byte addresses, control fields, reset values and encodings
`ifndef TMR16_DEFINES_VH
`define TMR16_DEFINES_VH

// Register addresses
`define TMR16_ADDR_CTRL     8'hF1
`define TMR16_ADDR_CNT_HI   8'hF2
`define TMR16_ADDR_CNT_LO   8'hF3
`define TMR16_ADDR_REF_HI   8'hF4
`define TMR16_ADDR_REF_LO   8'hF5

// Control register fields
`define TMR16_CTRL_PEND     0
`define TMR16_CTRL_IE       1
`define TMR16_CTRL_RUN      2
`define TMR16_CTRL_CLR      3
`define TMR16_CTRL_SEL_LO   4
`define TMR16_CTRL_SEL_HI   6

// Reset values
`define TMR16_CTRL_RST      8'h00
`define TMR16_REF_RST       16'hFFFF

// Clock source codes
`define TMR16_SEL_CARRIER   3'h0
`define TMR16_SEL_DIV256    3'h1
`define TMR16_SEL_DIV64     3'h2
`define TMR16_SEL_DIV8      3'h3
`define TMR16_SEL_DIV1      3'h4

// Interrupt identity
`define TMR16_IRQ_VECTOR    8'hE6
`define TMR16_IRQ_LEVEL     3'h2

`endif

// ---- tmr16_clk_sel.v ----
// Purpose: Prescaler and clock source selector for the interval timer
// Assumes: carrier_flipflop_out is synchronous to clk
// Notes:   Emits a one-cycle tick per period of the chosen source
`timescale 1ns/1ps
`include "tmr16_defines.vh"

module tmr16_clk_sel #(
	parameter PRE_W = 8
) (
	// Clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// Source choice
	input  wire [2:0] clk_sel,
	input  wire       carrier_flipflop_out,
	// Counting tick
	output reg        tick
);

	reg [PRE_W-1:0] prescale_r;
	reg             carrier_d_r;

	// Tick when the low n prescaler bits are all ones
	function ones_low;
		input [PRE_W-1:0] v;
		input integer     n;
		integer           i;
		begin
			ones_low = 1'b1;
			for (i = 0; i < PRE_W; i = i + 1) begin
				if (i < n && !v[i])
					ones_low = 1'b0;
			end
		end
	endfunction

	// Free-running prescaler and carrier edge history
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale_r  <= {PRE_W{1'b0}};
			carrier_d_r <= 1'b0;
		end else begin
			prescale_r  <= prescale_r + {{(PRE_W-1){1'b0}}, 1'b1};
			carrier_d_r <= carrier_flipflop_out;
		end
	end

	// Source multiplexer; unused codes give no tick
	always @* begin
		case (clk_sel)
		`TMR16_SEL_CARRIER: tick = carrier_flipflop_out & ~carrier_d_r;
		`TMR16_SEL_DIV256:  tick = ones_low(prescale_r, 8);
		`TMR16_SEL_DIV64:   tick = ones_low(prescale_r, 6);
		`TMR16_SEL_DIV8:    tick = ones_low(prescale_r, 3);
		`TMR16_SEL_DIV1:    tick = 1'b1;
		default:            tick = 1'b0;
		endcase
	end

endmodule

// ---- tmr16_interval.v ----
// Purpose: 16-bit interval timer with reference match and pending bit
// Assumes: Register port strobes are single-cycle and synchronous
// Notes:   Counter and reference are reached as high and low bytes
`timescale 1ns/1ps
`include "tmr16_defines.vh"

module tmr16_interval #(
	parameter PRE_W = 8
) (
	// Clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_we,
	input  wire       reg_re,
	output reg  [7:0] reg_rdata_r,
	// Carrier timer
	input  wire       carrier_flipflop_out,
	// Interrupt
	input  wire       irq_ack,
	output reg        match_irq_r,
	output reg  [2:0] irq_level_r,
	output reg  [7:0] irq_vector_r
);

	// Timing overview:
	// A read samples state as it stands before a write on the same edge.
	// The counter steps only on a tick of the chosen source while running.
	// A match both zeroes the counter and sets pending on that same edge.
	// A clear write beats a match for the counter, but pending still sets.
	// Pending set by a match beats both an acknowledge and a software clear.
	// The prescaler is free running and is never restarted by writes.

	// Control, counter and reference storage
	reg  [7:0]  ctrl_r;
	reg  [15:0] count_r;
	wire [15:0] ref_r;
	reg  [7:0]  ctrl_nxt;
	reg  [15:0] count_nxt;
	reg  [7:0]  rd_nxt;
	reg         irq_nxt;

	// Decoded strobes and status
	wire        tick;
	wire        running;
	wire        pend;
	wire        step;
	wire        match;
	wire        wr_ctrl;
	wire        clr_req;
	wire [2:0]  clk_sel;
	wire [1:0]  wr_ref_byte;
	wire [15:0] count_inc;

	// Reference reset value, sliced per byte lane
	localparam [15:0] REF_RST = `TMR16_REF_RST;

	// One-byte address compare; shared by every write decode
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// Stored control image; bit 3 is a strobe and bit 7 is unused
	function [7:0] ctrl_image;
		input [7:0] wdata;
		begin
			ctrl_image = wdata & 8'h77;
		end
	endfunction

	// Control fields
	assign clk_sel = ctrl_r[`TMR16_CTRL_SEL_HI:`TMR16_CTRL_SEL_LO];
	assign running = ctrl_r[`TMR16_CTRL_RUN];
	assign pend    = ctrl_r[`TMR16_CTRL_PEND];

	// Write strobes, one per writable location
	assign wr_ctrl        = reg_we && addr_hit(reg_addr, `TMR16_ADDR_CTRL);
	assign wr_ref_byte[1] = reg_we && addr_hit(reg_addr, `TMR16_ADDR_REF_HI);
	assign wr_ref_byte[0] = reg_we && addr_hit(reg_addr, `TMR16_ADDR_REF_LO);
	// Counter clear strobe: bit 3 of a control write, never stored
	assign clr_req        = wr_ctrl && reg_wdata[`TMR16_CTRL_CLR];

	// A counting step is a tick of the chosen source while running
	assign step      = running && tick;
	assign count_inc = count_r + 16'h0001;
	// Comparator sampled only on a step, so a held count cannot retrigger
	assign match     = step && (count_r == ref_r);

	// Source selection and prescaler; carrier edges and divided clock feed one tick
	tmr16_clk_sel #(
		.PRE_W (PRE_W)
	) u_clk_sel (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.clk_sel              (clk_sel),
		.carrier_flipflop_out (carrier_flipflop_out),
		.tick                 (tick)
	);

	// Control next value; clear bit never stores, a match beats any clear of pending
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = ctrl_image(reg_wdata);
		if (irq_ack)
			ctrl_nxt[`TMR16_CTRL_PEND] = 1'b0;
		if (match)
			ctrl_nxt[`TMR16_CTRL_PEND] = 1'b1;
		else if (wr_ctrl && !irq_ack)
			ctrl_nxt[`TMR16_CTRL_PEND] = reg_wdata[`TMR16_CTRL_PEND] & pend;
	end

	// Counter next value; a clear write wins over a match in the same cycle
	always @* begin
		count_nxt = count_r;
		if (clr_req)
			count_nxt = 16'h0000;
		else if (match)
			count_nxt = 16'h0000;
		else if (step)
			count_nxt = count_inc;
	end

	// Request follows the next pending bit, gated by enable and run
	always @* begin
		irq_nxt = ctrl_nxt[`TMR16_CTRL_PEND] & ctrl_nxt[`TMR16_CTRL_IE] & ctrl_nxt[`TMR16_CTRL_RUN];
	end

	// Read multiplexer; unmapped addresses read zero
	always @* begin
		case (reg_addr)
		`TMR16_ADDR_CTRL:   rd_nxt = ctrl_r;
		`TMR16_ADDR_CNT_HI: rd_nxt = count_r[15:8];
		`TMR16_ADDR_CNT_LO: rd_nxt = count_r[7:0];
		`TMR16_ADDR_REF_HI: rd_nxt = ref_r[15:8];
		`TMR16_ADDR_REF_LO: rd_nxt = ref_r[7:0];
		default:            rd_nxt = 8'h00;
		endcase
	end

	// Control register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl_r <= `TMR16_CTRL_RST;
		else
			ctrl_r <= ctrl_nxt;
	end

	// Counter register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			count_r <= 16'h0000;
		else
			count_r <= count_nxt;
	end

	// Reference bytes share one write pattern, one lane per byte
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1) begin : g_ref_lane
			reg [7:0] byte_r;
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst)
					byte_r <= REF_RST[lane*8 +: 8];
				else if (wr_ref_byte[lane])
					byte_r <= reg_wdata;
			end
			assign ref_r[lane*8 +: 8] = byte_r;
		end
	endgenerate

	// Read data register; holds until the next read strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata_r <= 8'h00;
		else if (reg_re)
			reg_rdata_r <= rd_nxt;
	end

	// Interrupt request register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			match_irq_r <= 1'b0;
		else
			match_irq_r <= irq_nxt;
	end

	// Fixed level and vector, presented once reset is released
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_level_r  <= 3'h0;
			irq_vector_r <= 8'h00;
		end else begin
			irq_level_r  <= `TMR16_IRQ_LEVEL;
			irq_vector_r <= `TMR16_IRQ_VECTOR;
		end
	end

endmodule

// ---- tmr16_monitor.sv ----
// Purpose: Port checker for the interval timer
// Assumes: Sees only top module ports
// Notes:   Bound below the module
`timescale 1ns/1ps
module tmr16_monitor (
	// Clock and reset
	input wire       clk,
	input wire       sys_rst,
	// Observed ports
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_we,
	input wire       reg_re,
	input wire [7:0] reg_rdata_r,
	input wire       match_irq_r,
	input wire [2:0] irq_level_r,
	input wire [7:0] irq_vector_r
);
	// Port relations
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_level_two: assert property (!$past(sys_rst) |-> irq_level_r == 3'h2) else $error("bad level");
	a_vector_fixed: assert property (!$past(sys_rst) |-> irq_vector_r == 8'hE6) else $error("bad vector");
	a_ctrl_rsvd: assert property (reg_re && reg_addr == 8'hF1 |=> reg_rdata_r[7] == 0 && reg_rdata_r[3] == 0)
		else $error("ctrl bits");
	a_unmapped_zero: assert property (reg_re && (reg_addr < 8'hF1 || reg_addr > 8'hF5) |=> reg_rdata_r == 8'h00)
		else $error("unmapped read");
	a_rdata_holds: assert property (!reg_re |=> $stable(reg_rdata_r)) else $error("rdata moved");
	a_irq_needs_en: assert property (reg_we && reg_addr == 8'hF1 && !reg_wdata[1] |=> !match_irq_r)
		else $error("irq without enable");
	a_irq_needs_run: assert property (reg_we && reg_addr == 8'hF1 && !reg_wdata[2] |=> !match_irq_r)
		else $error("irq without run");
	a_ref_readback: assert property (reg_we && reg_addr == 8'hF4 ##2 reg_re && reg_addr == 8'hF4
		|=> reg_rdata_r == $past(reg_wdata, 3)) else $error("ref readback");
endmodule
bind tmr16_interval tmr16_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .reg_re(reg_re), .reg_rdata_r(reg_rdata_r), .match_irq_r(match_irq_r),
	.irq_level_r(irq_level_r), .irq_vector_r(irq_vector_r));

// ---- test_timer16_interval_match.sv ----
// Purpose: Self-checking bench for the interval timer
// Assumes: 40 MHz clock, inputs driven 1 ns after edges
// Notes:   Prescaled counts checked with a small window
`timescale 1ns/1ps
module test_timer16_interval_match;
	reg         clk = 0, sys_rst = 1, reg_we = 0, reg_re = 0, carrier_flipflop_out = 0, irq_ack = 0;
	reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, got;
	reg  [15:0] cnt;
	wire [7:0]  reg_rdata_r, irq_vector_r;
	wire [2:0]  irq_level_r;
	wire        match_irq_r;
	integer     miscompares = 0, n_checks = 0, i;
	tmr16_interval dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata_r(reg_rdata_r), .carrier_flipflop_out(carrier_flipflop_out), .irq_ack(irq_ack),
		.match_irq_r(match_irq_r), .irq_level_r(irq_level_r), .irq_vector_r(irq_vector_r));
	// Clock
	initial forever #12.5 clk = ~clk;
	task chk(input [39:0] nm, input [15:0] e, input [15:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			#1 {reg_addr, reg_wdata, reg_we} = {a, d, 1'b1};
			@(posedge clk);
			#1 reg_we = 0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk);
			#1 {reg_addr, reg_re} = {a, 1'b1};
			@(posedge clk);
			#1 reg_re = 0;
			got = reg_rdata_r;
		end
	endtask
	task rdcnt;
		begin
			rd(8'hF2);
			cnt[15:8] = got;
			rd(8'hF3);
			cnt[7:0] = got;
		end
	endtask
	// One-cycle pulse on the carrier input (1) or on the acknowledge (0)
	task pulse(input which);
		begin
			@(posedge clk);
			if (which)
				#1 carrier_flipflop_out = 1;
			else
				#1 irq_ack = 1;
			@(posedge clk);
			#1 {carrier_flipflop_out, irq_ack} = 2'b00;
		end
	endtask
	task t_reset;
		begin
			rd(8'hF1);
			chk("ctrl", 0, got);
			chk("lvl", 2, irq_level_r);
			chk("vec", 16'hE6, irq_vector_r);
			rd(8'h10);
			chk("unmap", 0, got);
			wr(8'hF4, 8'h5A);
			rd(8'hF4);
			chk("ref", 16'h5A, got);
			$display("reset test ended");
		end
	endtask
	task t_poll;
		begin
			wr(8'hF4, 8'h00);
			wr(8'hF5, 8'h02);
			wr(8'hF1, 8'h4C);
			repeat (20) @(posedge clk);
			wr(8'hF1, 8'h41);
			rd(8'hF1);
			chk("pend", 1, got[0]);
			chk("irq", 0, match_irq_r);
			rdcnt;
			// 22 steps at /1 with period 3 leave the count at 1
			chk("wrap", 16'h0001, cnt);
			wr(8'hF1, 8'h07);
			chk("irq", 1, match_irq_r);
			pulse(1'b0);
			chk("ack", 0, match_irq_r);
			rd(8'hF1);
			chk("pclr", 0, got[0]);
			wr(8'hF1, 8'h4C);
			repeat (6) @(posedge clk);
			wr(8'hF1, 8'h41);
			rd(8'hF1);
			chk("pend2", 1, got[0]);
			wr(8'hF1, 8'h40);
			rd(8'hF1);
			chk("swclr", 0, got[0]);
			$display("poll test ended");
		end
	endtask
	task t_carrier;
		begin
			wr(8'hF5, 8'h10);
			wr(8'hF1, 8'h0C);
			for (i = 0; i < 3; i = i + 1)
				pulse(1'b1);
			repeat (2) @(posedge clk);
			wr(8'hF1, 8'h00);
			rdcnt;
			chk("carr", 3, cnt);
			wr(8'hF1, 8'h08);
			rdcnt;
			chk("clr", 0, cnt);
			$display("carrier test ended");
		end
	endtask
	task t_div;
		begin
			wr(8'hF5, 8'hFF);
			wr(8'hF4, 8'hFF);
			for (i = 1; i < 5; i = i + 1) begin
				wr(8'hF1, {1'b0, i[2:0], 4'hC});
				repeat (256) @(posedge clk);
				wr(8'hF1, {1'b0, i[2:0], 4'h0});
				rdcnt;
				chk("div", 1, cnt >= (256 >> (i == 1 ? 8 : i == 2 ? 6 : i == 3 ? 3 : 0)) && cnt <= (259 >>
					(i == 1 ? 8 : i == 2 ? 6 : i == 3 ? 3 : 0)) + 2);
			end
			$display("divider test ended");
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Watchdog
	initial begin
		#100000;
		miscompares = miscompares + 1;
		finish_test;
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 0;
		t_reset;
		t_poll;
		t_carrier;
		t_div;
		finish_test;
	end
endmodule
